// *** hw/bscrc_pkg.sv ***
// Package: shared constants and types for the byte serial CRC engine
package bscrc_pkg;
  localparam int          BYTE_W      = 8;
  localparam int          RES_W       = 32;
  localparam int          STEPS       = 8;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [15:0] POLY16      = 16'h1021;
  localparam logic [31:0] POLY32      = 32'h04C11DB7;
  localparam logic [31:0] INIT_ZERO   = 32'h00000000;
  localparam logic [31:0] INIT_ONES   = 32'hFFFFFFFF;
  localparam logic [1:0]  PTR_RESET   = 2'h0;
  localparam logic [3:0]  CNT_RESET   = 4'h0;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam int          MSB16       = 15;
  localparam int          MSB32       = 31;

  typedef enum logic {
    BSCRC_W16,
    BSCRC_W32
  } bscrc_width_e;

  typedef enum logic [1:0] {
    BSCRC_IDLE,
    BSCRC_SHIFT
  } bscrc_state_e;

  // Configuration word that software drives
  typedef struct packed {
    bscrc_width_e width;
    logic         init_ones;
    logic [1:0]   ptr;
  } bscrc_cfg_s;
endpackage

// *** hw/bscrc_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module bscrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    out_valid_o = (cnt_q != '0);
    out_data_o  = mem_q[rd_q];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_d        = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d        = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("FIFO count beyond depth");
endmodule

// *** hw/bscrc_engine.sv ***
// Byte serial CRC engine with input FIFO, result pointer and bit reverser
`timescale 1ns/1ps
module bscrc_engine (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire bscrc_pkg::bscrc_cfg_s cfg_i,
  input  wire logic                  init_i,
  input  wire logic                  byte_valid_i,
  input  wire logic [7:0]            crc_input_byte_i,
  output logic                       byte_ready_o,
  output logic                       busy_o,
  output logic [7:0]                 result_byte_data_o,
  input  wire logic                  rev_wr_i,
  input  wire logic [7:0]            rev_byte_i,
  output logic [7:0]                 rev_byte_o
);
  logic                     rst_meta_q;
  logic                     rst_sync_n_q;
  logic                     f_valid;
  logic                     f_ready;
  logic [7:0]               f_data;
  logic                     in_ready;
  bscrc_pkg::bscrc_state_e  state_q;
  bscrc_pkg::bscrc_state_e  state_d;
  logic [31:0]              crc_q;
  logic [31:0]              crc_d;
  logic [3:0]               cnt_q;
  logic [3:0]               cnt_d;
  logic [7:0]               rd_q;
  logic [7:0]               rd_d;
  logic [7:0]               rev_q;
  logic [7:0]               rev_d;
  logic                     ready_q;
  logic                     busy_q;
  logic                     busy_d;
  logic                     msb;
  logic [31:0]              shifted;
  logic [31:0]              poly;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  bscrc_fifo #(
    .WIDTH (bscrc_pkg::BYTE_W),
    .DEPTH (bscrc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_sync_n_q),
    .in_valid_i  (byte_valid_i),
    .in_ready_o  (in_ready),
    .in_data_i   (crc_input_byte_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // Engine takes a byte only when idle and not initialising
  assign f_ready = (state_q == bscrc_pkg::BSCRC_IDLE) && !init_i;

  always_comb begin
    // Feedback bit and polynomial follow the width selection
    if (cfg_i.width == bscrc_pkg::BSCRC_W16) begin
      msb  = crc_q[bscrc_pkg::MSB16];
      poly = {16'h0000, bscrc_pkg::POLY16};
    end else begin
      msb  = crc_q[bscrc_pkg::MSB32];
      poly = bscrc_pkg::POLY32;
    end
    shifted = {crc_q[30:0], 1'b0};
    if (cfg_i.width == bscrc_pkg::BSCRC_W16) begin
      shifted[31:16] = 16'h0000;
    end
    state_d = state_q;
    crc_d   = crc_q;
    cnt_d   = cnt_q;
    if (init_i) begin
      crc_d   = cfg_i.init_ones ? bscrc_pkg::INIT_ONES
                                : bscrc_pkg::INIT_ZERO;
      if (cfg_i.width == bscrc_pkg::BSCRC_W16) begin
        crc_d[31:16] = 16'h0000;
      end
      state_d = bscrc_pkg::BSCRC_IDLE;
      cnt_d   = bscrc_pkg::CNT_RESET;
    end else begin
      unique case (state_q)
        bscrc_pkg::BSCRC_IDLE: begin
          if (f_valid) begin
            if (cfg_i.width == bscrc_pkg::BSCRC_W16) begin
              crc_d[15:8] = crc_q[15:8] ^ f_data;
            end else begin
              crc_d[31:24] = crc_q[31:24] ^ f_data;
            end
            cnt_d   = bscrc_pkg::CNT_RESET;
            state_d = bscrc_pkg::BSCRC_SHIFT;
          end
        end
        bscrc_pkg::BSCRC_SHIFT: begin
          if (msb) begin
            crc_d = shifted ^ poly;
          end else begin
            crc_d = shifted;
          end
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'(bscrc_pkg::STEPS - 1)) begin
            state_d = bscrc_pkg::BSCRC_IDLE;
          end
        end
        default: begin
          state_d = bscrc_pkg::BSCRC_IDLE;
        end
      endcase
    end
    // Pointer picks one result byte for reading
    rd_d  = crc_d[8*cfg_i.ptr +: 8];
    rev_d = rev_q;
    if (rev_wr_i) begin
      for (int i = 0; i < 8; i++) begin
        rev_d[i] = rev_byte_i[7-i];
      end
    end
    busy_d = (state_d == bscrc_pkg::BSCRC_SHIFT) || f_valid;
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      state_q <= bscrc_pkg::BSCRC_IDLE;
      crc_q   <= bscrc_pkg::INIT_ZERO;
      cnt_q   <= bscrc_pkg::CNT_RESET;
      rd_q    <= bscrc_pkg::BYTE_RESET;
      rev_q   <= bscrc_pkg::BYTE_RESET;
      ready_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      crc_q   <= crc_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
      rev_q   <= rev_d;
      ready_q <= in_ready;
      busy_q  <= busy_d;
    end
  end

  assign byte_ready_o       = ready_q;
  assign busy_o             = busy_q;
  assign result_byte_data_o = rd_q;
  assign rev_byte_o         = rev_q;

  a_shift_eight_steps: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (state_q == bscrc_pkg::BSCRC_IDLE && f_valid && !init_i) |=>
      (state_q == bscrc_pkg::BSCRC_SHIFT && !init_i) [*8] ##1
      (init_i || state_q == bscrc_pkg::BSCRC_IDLE))
    else $error("Byte update did not take eight steps");

  a_shift_with_poly: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (state_q == bscrc_pkg::BSCRC_SHIFT && !init_i && msb) |=>
      crc_q == (($past(cfg_i.width) == bscrc_pkg::BSCRC_W32) ?
        ({$past(crc_q[30:0]), 1'b0} ^ bscrc_pkg::POLY32) :
        {16'h0000, {$past(crc_q[14:0]), 1'b0} ^ bscrc_pkg::POLY16}))
    else $error("Feedback step missed the polynomial");

  a_shift_no_poly: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (state_q == bscrc_pkg::BSCRC_SHIFT && !init_i && !msb) |=>
      crc_q == (($past(cfg_i.width) == bscrc_pkg::BSCRC_W32) ?
        {$past(crc_q[30:0]), 1'b0} :
        {16'h0000, $past(crc_q[14:0]), 1'b0}))
    else $error("Plain step applied the polynomial");

  a_xor_top_byte: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (state_q == bscrc_pkg::BSCRC_IDLE && f_valid && !init_i &&
     cfg_i.width == bscrc_pkg::BSCRC_W32) |=>
      crc_q[31:24] == ($past(crc_q[31:24]) ^ $past(f_data)))
    else $error("Input byte not folded into top bits");

  a_init_value: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    init_i |=>
      crc_q == (!$past(cfg_i.init_ones) ? bscrc_pkg::INIT_ZERO :
        ($past(cfg_i.width) == bscrc_pkg::BSCRC_W32) ?
          bscrc_pkg::INIT_ONES :
          {16'h0000, bscrc_pkg::INIT_ONES[15:0]}))
    else $error("Initial value not loaded");

  a_poly16_value: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (cfg_i.width == bscrc_pkg::BSCRC_W16) |->
      poly == 32'h00001021)
    else $error("Wrong 16-bit polynomial");

  a_width16_upper: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    (cfg_i.width == bscrc_pkg::BSCRC_W16 && $stable(cfg_i.width)) |=>
      crc_q[31:16] == 16'h0000 ||
      $past(cfg_i.width) != bscrc_pkg::BSCRC_W16)
    else $error("Upper half set in 16-bit mode");

  a_ptr_select: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    1'b1 |=> rd_q == 8'(crc_q >> (8 * $past(cfg_i.ptr))))
    else $error("Result byte does not follow pointer");

  a_rev_mirror: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n_q)
    rev_wr_i |=> {rev_q[0], rev_q[1], rev_q[2], rev_q[3],
                  rev_q[4], rev_q[5], rev_q[6], rev_q[7]} ==
                 $past(rev_byte_i))
    else $error("Reversed byte is wrong");

  c_byte_16: cover property (@(posedge core_clk_i)
    state_q == bscrc_pkg::BSCRC_SHIFT &&
    cfg_i.width == bscrc_pkg::BSCRC_W16);
  c_byte_32: cover property (@(posedge core_clk_i)
    state_q == bscrc_pkg::BSCRC_SHIFT &&
    cfg_i.width == bscrc_pkg::BSCRC_W32);
  c_fifo_full: cover property (@(posedge core_clk_i) !in_ready);
  c_reverse: cover property (@(posedge core_clk_i) rev_wr_i);
endmodule

// *** test/bscrc_tb.sv ***
// Self-checking bench for the byte serial CRC engine
`timescale 1ns/1ps
module testbench;
  logic                  core_clk_i       = 1'b0;
  logic                  rst_n_i          = 1'b0;
  bscrc_pkg::bscrc_cfg_s cfg_i;
  logic                  init_i           = 1'b0;
  logic                  byte_valid_i     = 1'b0;
  logic [7:0]            crc_input_byte_i = 8'h00;
  logic                  byte_ready_o;
  logic                  busy_o;
  logic [7:0]            result_byte_data_o;
  logic                  rev_wr_i         = 1'b0;
  logic [7:0]            rev_byte_i       = 8'h00;
  logic [7:0]            rev_byte_o;
  int                    err_count        = 0;
  int                    checks_done      = 0;
  int                    seed             = 32'h0AD8D7B5;
  logic [31:0]           model_q;
  logic [7:0]            bytes [$];

  always #25 core_clk_i = ~core_clk_i;

  bscrc_engine u_bscrc_engine (
    .core_clk_i         (core_clk_i),
    .rst_n_i            (rst_n_i),
    .cfg_i              (cfg_i),
    .init_i             (init_i),
    .byte_valid_i       (byte_valid_i),
    .crc_input_byte_i   (crc_input_byte_i),
    .byte_ready_o       (byte_ready_o),
    .busy_o             (busy_o),
    .result_byte_data_o (result_byte_data_o),
    .rev_wr_i           (rev_wr_i),
    .rev_byte_i         (rev_byte_i),
    .rev_byte_o         (rev_byte_o)
  );

  // Reference update: fold the byte into the top, then eight steps
  function automatic logic [31:0] fold(input logic [31:0] acc,
                                       input logic [7:0]  b,
                                       input logic        w32);
    logic [31:0] a;
    a = w32 ? acc ^ {b, 24'h000000} : {16'h0000, acc[15:0] ^ {b, 8'h00}};
    for (int i = 0; i < 8; i++) begin
      if (w32) a = a[31] ? (a << 1) ^ bscrc_pkg::POLY32 : a << 1;
      else a = a[15] ? ((a << 1) ^ bscrc_pkg::POLY16) & 32'h0000FFFF
                     : (a << 1) & 32'h0000FFFF;
    end
    return a;
  endfunction

  function automatic logic [7:0] mirror(input logic [7:0] b);
    for (int i = 0; i < 8; i++) mirror[i] = b[7-i];
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #5;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a flag to reach a level
  task automatic wait_until(input logic sel_busy, input logic v);
    int n;
    n = 0;
    tick(3);
    while (((sel_busy ? busy_o : byte_ready_o) !== v) && n < 200) begin
      tick(1);
      n++;
    end
    if ((sel_busy ? busy_o : byte_ready_o) !== v) begin
      err_count++;
      $display("wrong value at %0t: wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic start(input logic w32, input logic ones);
    cfg_i.width     = bscrc_pkg::bscrc_width_e'(w32);
    cfg_i.init_ones = ones;
    cfg_i.ptr       = 2'h0;
    init_i          = 1'b1;
    tick(1);
    init_i  = 1'b0;
    model_q = ones ? (w32 ? 32'hFFFFFFFF : 32'h0000FFFF) : 32'h00000000;
    tick(1);
  endtask

  // Back to back bytes, at most nine: eight in the FIFO and one in the engine
  task automatic send(input logic w32);
    foreach (bytes[i]) begin
      byte_valid_i     = 1'b1;
      crc_input_byte_i = bytes[i];
      model_q          = fold(model_q, bytes[i], w32);
      tick(1);
    end
    byte_valid_i = 1'b0;
    tick(1);
    // Nine bytes back to back leave the FIFO full for two cycles
    check(8'(byte_ready_o), 8'(bytes.size() < 9));
    wait_until(1'b1, 1'b0);
  endtask

  task automatic check_ptr(input logic [1:0] p, input logic [7:0] exp);
    cfg_i.ptr = p;
    tick(2);
    check(result_byte_data_o, exp);
  endtask

  task automatic read_result(input logic w32);
    for (int p = 0; p < (w32 ? 4 : 2); p++) begin
      check_ptr(p[1:0], model_q[8*p +: 8]);
    end
  endtask

  initial begin
    logic [7:0] b;
    cfg_i = '0;
    tick(5);
    rst_n_i = 1'b1;
    wait_until(1'b0, 1'b1);
    // Nine ASCII digits from zero in 16-bit mode, in two bursts
    start(1'b0, 1'b0);
    check_ptr(2'h0, 8'h00);
    bytes = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
    send(1'b0);
    bytes = '{8'h36, 8'h37, 8'h38, 8'h39};
    send(1'b0);
    check_ptr(2'h0, 8'hC3);
    check_ptr(2'h1, 8'h31);
    $display("test known answer done");
    for (int t = 0; t < 8; t++) begin
      start(t[0], t[1]);
      check_ptr(2'h0, t[1] ? 8'hFF : 8'h00);
      bytes = {};
      repeat (($unsigned($random(seed)) % 8) + 1) begin
        bytes.push_back(t[2] ? 8'hFF : 8'($random(seed)));
      end
      send(t[0]);
      read_result(t[0]);
      $display("test stream %0d done", t);
    end
    // Corner case: nine bytes fill the FIFO while the engine works
    start(1'b1, 1'b1);
    bytes = {};
    repeat (9) bytes.push_back(8'($random(seed)));
    send(1'b1);
    read_result(1'b1);
    $display("test full fifo done");
    for (int t = 0; t < 8; t++) begin
      b          = (t == 0) ? 8'h01 : 8'($random(seed));
      rev_byte_i = b;
      rev_wr_i   = 1'b1;
      tick(1);
      rev_wr_i = 1'b0;
      tick(1);
      check(rev_byte_o, mirror(b));
    end
    $display("test reversal done");
    // Reset again in mid-run: result and mirror return to zero
    rst_n_i = 1'b0;
    tick(2);
    check(result_byte_data_o, 8'h00);
    check(rev_byte_o, 8'h00);
    rst_n_i = 1'b1;
    wait_until(1'b0, 1'b1);
    check_ptr(2'h0, 8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule
